// *** design/lamp_pkg.sv ***
// Purpose: Shared constants and carrier types for the status lamp block
// Assumes: 100 MHz system clock, 32-bit classic Wishbone register access
// Notes: Offsets are byte addresses of aligned words
package lamp_pkg;
  // ==========================================================
  // Clock and timing
  // ==========================================================
  localparam int CLK_HZ = 100_000_000;
  localparam int BLINK_MS = 250;                       // Half period of flashing
  localparam int BLINK_CYC = CLK_HZ / 1000 * BLINK_MS;
  localparam int STRETCH_MS = 50;                      // Least activity lamp hold, gated by the blink phase
  localparam int STRETCH_CYC = CLK_HZ / 1000 * STRETCH_MS;
  localparam int TEST_MS = 1000;                       // Power-up lamp test length
  localparam int TEST_CYC = CLK_HZ / 1000 * TEST_MS;
  localparam int BURST_LIMIT = 8;                      // Errors in a row giving solid red
  // ==========================================================
  // Register map
  // ==========================================================
  localparam logic [7:0] OFS_CTRL = 8'h00;   // Control bits
  localparam logic [7:0] OFS_STAT = 8'h04;   // Live state, read only
  localparam logic [7:0] OFS_IRQ = 8'h08;    // Sticky events, write one to clear
  localparam logic [7:0] OFS_MASK = 8'h0C;   // Interrupt mask
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] MASK_RST = 32'h0000_0000;
  localparam int CTRL_VARIANT = 0;           // Variant lamp encoding select
  localparam int CTRL_PASSTHRU = 1;          // Debug pass-through active
  localparam int CTRL_ROLE_SLAVE = 2;        // Slave/adapter/server role
  localparam int IRQ_FAULT = 0;              // Program failure seen
  localparam int IRQ_APP_ERR = 1;            // Application error seen
  localparam int IRQ_PORT_ERR = 2;           // Any port error seen
  // ==========================================================
  // Carrier types
  // ==========================================================
  typedef struct packed {
    logic [31:0] adr;
    logic [31:0] dat;
    logic [3:0] sel;
    logic we;
    logic cyc;
    logic stb;
  } wb_req_t;
  typedef struct packed {
    logic [31:0] dat;
    logic ack;
  } wb_rsp_t;
  typedef struct packed {
    logic power;
    logic fault;
    logic cfg;
    logic app_err;
  } lamps_t;
endpackage

// *** design/status_lamps.sv ***
// Purpose: Front-panel status lamp drive for a serial protocol gateway
// Assumes: Event inputs come from logic on clk; reset button is a pin
// Notes: Lamps are active high; outputs all come from flip-flops
// What this block does
// R1: Fault lamp solid red after program failure, until reset
// R2: Config lamp amber while configuration mode lasts
// R3: Config mode after power-up, reset button, boot command
// R4: App error lamp flashes while any error present
// R5: Error flag cleared per command or receipt
// R6: Recurring errors show app error lamp solid
// R7: Port activity lamp flashes during transfers
// R8: Port error lamp red on communication error
// R9: Brief lamp test shortly after power-up
// R10: Variant: fault plus config shows pass-through
// R11: Variant: fault alone shows critical failure
// R12: Each port has own independent two lamps
// R13: One blink generator; activity pulses stretched
//
// The implementer's own choices: the Wishbone slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module status_lamps
  import lamp_pkg::*;
#(
  parameter int NPORTS = 4,
  parameter int BLINK_COUNT = BLINK_CYC,
  parameter int STRETCH_COUNT = STRETCH_CYC,
  parameter int TEST_COUNT = TEST_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic reset_button_n,        // Pin, synchronised here
  input wire logic prog_failed,           // Control program failed or terminated
  input wire logic cfg_busy,              // Load, apply and init in progress
  input wire logic boot_cmd,              // Cold or warm boot command pulse
  input wire logic cmd_start,             // Master/client command attempt pulse
  input wire logic data_rx,               // Slave/server data receipt pulse
  input wire logic app_err_evt,           // Application error pulse
  input wire logic [NPORTS-1:0] port_tx,  // Per-port transmit activity
  input wire logic [NPORTS-1:0] port_rx,  // Per-port receive activity
  input wire logic [NPORTS-1:0] port_err, // Per-port communication error pulse
  input wire wb_req_t wb_req,
  output wb_rsp_t wb_rsp,
  output lamps_t lamps,
  output logic [NPORTS-1:0] port_activity_lamp,
  output logic [NPORTS-1:0] port_error_lamp,
  output logic irq
);
  // ==========================================================
  // State
  // ==========================================================
  typedef enum logic [1:0] {ST_TEST, ST_CFG, ST_RUN} mode_t;
  typedef struct packed {
    logic [1:0] btn_sync;                 // Reset button synchroniser
    logic btn_prev;                       // Last synchronised level
    mode_t mode;                          // Lamp test, config, run
    logic cfg_seen;                       // Config work has begun
    logic [31:0] test_cnt;                // Lamp test countdown
    logic [31:0] blink_cnt;               // Blink generator count
    logic blink;                          // Blink phase
    logic fault;                          // Latched program failure
    logic err_flag;                       // Application error flag
    logic [3:0] err_run;                  // Errors since a clear that found the flag already clear
    logic [NPORTS-1:0][31:0] act_cnt;     // Activity stretch counters
    logic [NPORTS-1:0][31:0] perr_cnt;    // Error stretch counters
    logic [31:0] ctrl;
    logic [31:0] irq_stat;
    logic [31:0] mask;
    wb_rsp_t rsp;
    lamps_t lamps;
    logic [NPORTS-1:0] act_lamp;
    logic [NPORTS-1:0] err_lamp;
    logic irq;
  } state_t;
  state_t s_reg, s_next;
  // Bus decode, button edge, error burst and event helpers
  logic bus_hit;
  logic bus_wr;
  logic [31:0] wmask;
  logic [31:0] rdata;
  logic btn_press;
  logic err_solid;
  logic [31:0] ev;
  always_comb begin
    bus_hit = wb_req.cyc && wb_req.stb && !s_reg.rsp.ack;
    bus_wr = bus_hit && wb_req.we;
    wmask = {{8{wb_req.sel[3]}}, {8{wb_req.sel[2]}}, {8{wb_req.sel[1]}}, {8{wb_req.sel[0]}}};
    btn_press = s_reg.btn_prev && !s_reg.btn_sync[1];
    err_solid = (s_reg.err_run >= 4'(BURST_LIMIT));
  end
  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    s_next = s_reg;
    // Button synchroniser, second stage feeds the edge detector
    s_next.btn_sync = {s_reg.btn_sync[0], reset_button_n};
    s_next.btn_prev = s_reg.btn_sync[1];
    // Single blink generator for every flashing lamp
    if (s_reg.blink_cnt >= 32'(BLINK_COUNT - 1)) begin // R13
      s_next.blink_cnt = '0;
      s_next.blink = !s_reg.blink;
    end else begin
      s_next.blink_cnt = s_reg.blink_cnt + 32'd1;
    end
    // Program failure latches until reset
    if (prog_failed) begin
      s_next.fault = 1'b1; // R1
    end
    // Mode sequencing
    case (s_reg.mode)
      ST_TEST: begin
        // Lamp test then configuration
        if (s_reg.test_cnt == '0) begin
          s_next.mode = ST_CFG; // R3
          s_next.cfg_seen = 1'b0;
        end else begin
          s_next.test_cnt = s_reg.test_cnt - 32'd1; // R9
        end
      end
      ST_CFG: begin
        // Leave once config work has started and ended
        if (cfg_busy) begin
          s_next.cfg_seen = 1'b1;
        end else if (s_reg.cfg_seen) begin
          s_next.mode = ST_RUN; // R2
        end
      end
      ST_RUN: begin
        if (boot_cmd) begin
          s_next.mode = ST_CFG; // R3
          s_next.cfg_seen = 1'b0;
        end
      end
      default: begin
        s_next.mode = ST_CFG;
      end
    endcase
    // Reset button restarts configuration and clears the fault
    if (btn_press) begin
      s_next.mode = ST_CFG; // R3
      s_next.cfg_seen = 1'b0;
      s_next.fault = 1'b0; // R1
    end
    // Application error flag; error wins over same-cycle clear
    if (app_err_evt) begin
      s_next.err_flag = 1'b1;
      if (!err_solid) begin
        s_next.err_run = s_reg.err_run + 4'd1; // R6
      end
    end else if (s_reg.ctrl[CTRL_ROLE_SLAVE] ? data_rx : cmd_start) begin
      s_next.err_flag = 1'b0; // R5
      if (!s_reg.err_flag) begin
        s_next.err_run = '0;
      end
    end
    // Per-port stretchers
    for (int i = 0; i < NPORTS; i++) begin
      if (port_tx[i] || port_rx[i]) begin
        s_next.act_cnt[i] = 32'(STRETCH_COUNT); // R13
      end else if (s_reg.act_cnt[i] != '0) begin
        s_next.act_cnt[i] = s_reg.act_cnt[i] - 32'd1;
      end
      if (port_err[i]) begin
        s_next.perr_cnt[i] = 32'(STRETCH_COUNT); // R8
      end else if (s_reg.perr_cnt[i] != '0) begin
        s_next.perr_cnt[i] = s_reg.perr_cnt[i] - 32'd1;
      end
    end
    // Lamp outputs
    s_next.lamps.power = 1'b1;
    if (s_reg.mode == ST_TEST) begin
      s_next.lamps.fault = 1'b1; // R9
      s_next.lamps.cfg = 1'b1;
      s_next.lamps.app_err = 1'b1;
      s_next.act_lamp = '1;
      s_next.err_lamp = '1;
    end else begin
      if (s_reg.ctrl[CTRL_VARIANT] && s_reg.ctrl[CTRL_PASSTHRU]) begin
        s_next.lamps.fault = 1'b1; // R10
        s_next.lamps.cfg = 1'b1;
      end else if (s_reg.ctrl[CTRL_VARIANT] && s_reg.fault) begin
        s_next.lamps.fault = 1'b1; // R11
        s_next.lamps.cfg = 1'b0;
      end else begin
        s_next.lamps.fault = s_reg.fault; // R1
        s_next.lamps.cfg = (s_reg.mode == ST_CFG); // R2
      end
      s_next.lamps.app_err = err_solid || (s_reg.err_flag && s_reg.blink); // R4 R6
      for (int i = 0; i < NPORTS; i++) begin
        s_next.act_lamp[i] = (s_reg.act_cnt[i] != '0) && s_reg.blink; // R7 R12
        s_next.err_lamp[i] = (s_reg.perr_cnt[i] != '0); // R8 R12
      end
    end
    // Sticky event bits; set beats write-one-to-clear
    ev = '0;
    ev[IRQ_FAULT] = prog_failed;
    ev[IRQ_APP_ERR] = app_err_evt;
    ev[IRQ_PORT_ERR] = |port_err;
    // Register access, one-cycle ack
    rdata = '0;
    case (wb_req.adr[7:0])
      OFS_CTRL: rdata = s_reg.ctrl;
      OFS_STAT: rdata = {26'd0, err_solid, s_reg.err_flag, s_reg.fault, s_reg.mode == ST_CFG,
                         s_reg.mode == ST_TEST, 1'b0};
      OFS_IRQ: rdata = s_reg.irq_stat;
      OFS_MASK: rdata = s_reg.mask;
      default: rdata = '0;
    endcase
    s_next.rsp.ack = bus_hit;
    s_next.rsp.dat = bus_hit ? rdata : '0;
    s_next.irq_stat = s_reg.irq_stat;
    if (bus_wr) begin
      case (wb_req.adr[7:0])
        OFS_CTRL: s_next.ctrl = (s_reg.ctrl & ~wmask) | (wb_req.dat & wmask);
        OFS_IRQ: s_next.irq_stat = s_reg.irq_stat & ~(wb_req.dat & wmask);
        OFS_MASK: s_next.mask = (s_reg.mask & ~wmask) | (wb_req.dat & wmask);
        default: begin
        end
      endcase
    end
    s_next.irq_stat = s_next.irq_stat | ev;
    // A set mask bit blocks its event from the interrupt line
    s_next.irq = |(s_reg.irq_stat & ~s_reg.mask);
  end
  // ==========================================================
  // State register
  // ==========================================================
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_reg <= '0;
      s_reg.btn_sync <= 2'b11;
      s_reg.btn_prev <= 1'b1;
      s_reg.mode <= ST_TEST;
      s_reg.test_cnt <= 32'(TEST_COUNT);
      s_reg.ctrl <= CTRL_RST;
      s_reg.mask <= MASK_RST;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end
  assign wb_rsp = s_reg.rsp;
  assign lamps = s_reg.lamps;
  assign port_activity_lamp = s_reg.act_lamp;
  assign port_error_lamp = s_reg.err_lamp;
  assign irq = s_reg.irq;
  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_fault_latches: assert property (ce && prog_failed && !btn_press && !s_reg.ctrl[CTRL_VARIANT]
    && s_reg.mode != ST_TEST ##1 ce |=> lamps.fault) else $error("fault lamp not lit"); // R1
  a_cfg_lamp_mode: assert property (ce && s_reg.mode != ST_TEST && !s_reg.ctrl[CTRL_VARIANT]
    |=> lamps.cfg == ($past(s_reg.mode) == ST_CFG)) else $error("cfg lamp mismatch"); // R2
  a_boot_enters_cfg: assert property (ce && boot_cmd && s_reg.mode == ST_RUN
    |=> s_reg.mode == ST_CFG) else $error("boot did not enter cfg"); // R3
  a_err_clear: assert property (ce && !app_err_evt && !s_reg.ctrl[CTRL_ROLE_SLAVE] && cmd_start
    |=> !s_reg.err_flag) else $error("error flag not cleared"); // R5
  a_err_solid: assert property (ce && err_solid && s_reg.mode != ST_TEST
    |=> lamps.app_err) else $error("solid error lamp dark"); // R6
  a_act_dark_idle: assert property (ce && s_reg.mode != ST_TEST && s_reg.act_cnt[0] == '0
    |=> !port_activity_lamp[0]) else $error("activity lamp lit idle"); // R7
  a_perr_lit: assert property (ce && port_err[0] ##1 ce && s_reg.mode != ST_TEST
    |=> port_error_lamp[0]) else $error("port error lamp dark"); // R8
  a_test_lamps: assert property (ce && s_reg.mode == ST_TEST
    |=> lamps.cfg && lamps.app_err) else $error("lamp test missing"); // R9
  a_passthru: assert property (ce && s_reg.mode != ST_TEST && s_reg.ctrl[CTRL_VARIANT]
    && s_reg.ctrl[CTRL_PASSTHRU] |=> lamps.fault && lamps.cfg) else $error("pass-through lamps"); // R10
  a_irq_sticky: assert property (ce && prog_failed |=> s_reg.irq_stat[IRQ_FAULT])
    else $error("fault event lost");
  c_fault: cover property (ce && lamps.fault);
  c_boot: cover property (ce && boot_cmd && s_reg.mode == ST_RUN);
  c_solid: cover property (err_solid);
  c_activity: cover property (port_activity_lamp[0]);
endmodule
`default_nettype wire

// *** tb/lamp_viewer.sv ***
// Purpose: Operator model that watches the front-panel lamps
// Assumes: Lamps are active high and steady between clk edges
// Notes: Records lit and dark sightings since the last clear
`timescale 1ns/1ps
`default_nettype none
module lamp_viewer #(
  parameter int W = 12
) (
  input wire logic clk,
  input wire logic clear,
  input wire logic [W-1:0] lamp,
  output logic [W-1:0] lit_seen,
  output logic [W-1:0] dark_seen
);
  // ==========================================================
  // Sighting record
  // ==========================================================
  // Solid, dark or flashing is told from both sightings
  always_ff @(posedge clk) begin
    if (clear) begin
      lit_seen <= '0;
      dark_seen <= '0;
    end else begin
      lit_seen <= lit_seen | lamp;
      dark_seen <= dark_seen | ~lamp;
    end
  end
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// Purpose: Self-checking bench for the status lamp block
// Assumes: Short blink, stretch and test counts set here
// Notes: Lamp classes come from a small model in int form
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import lamp_pkg::*;
  // ==========================================================
  // Signals
  // ==========================================================
  logic clk, arst_n, btn_n, cfg_busy, clr, ce;
  logic [4:0] ev; // Failure, boot, command, receipt, error
  logic [3:0] tx, rx, perr, pa, pe;
  wb_req_t req;
  wb_rsp_t rsp;
  lamps_t lamps;
  logic irq;
  logic [11:0] lit, dark;
  logic [31:0] q;
  int bad_count, n_tests, p;
  int m[4]; // Model: power, fault, cfg, err; 0 dark 1 flash 2 solid
  status_lamps #(.NPORTS(4), .BLINK_COUNT(4), .STRETCH_COUNT(6), .TEST_COUNT(10))
    status_lamps_inst (.clk(clk), .arst_n(arst_n), .ce(ce), .reset_button_n(btn_n),
    .prog_failed(ev[0]), .cfg_busy(cfg_busy), .boot_cmd(ev[1]), .cmd_start(ev[2]),
    .data_rx(ev[3]), .app_err_evt(ev[4]), .port_tx(tx), .port_rx(rx), .port_err(perr),
    .wb_req(req), .wb_rsp(rsp), .lamps(lamps), .port_activity_lamp(pa),
    .port_error_lamp(pe), .irq(irq));
  lamp_viewer #(.W(12)) lamp_viewer_inst (.clk(clk), .clear(clr),
    .lamp({lamps, pa, pe}), .lit_seen(lit), .dark_seen(dark));
  // ==========================================================
  // Tasks
  // ==========================================================
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask
  // Lamp class; 3 only asks for a lit sighting
  task automatic cls(input int i, input int c);
    logic [1:0] g, e;
    g = {lit[i], dark[i]};
    e = (c == 0) ? 2'b01 : (c == 1) ? 2'b11 : 2'b10;
    if (c == 3) g[0] = 1'b0;
    chk({30'h0000_0000, g}, {30'h0000_0000, e});
  endtask
  task automatic watch(input int n);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (n) @(posedge clk);
  endtask
  // Module lamps against the model
  task automatic expect4();
    watch(12);
    for (int i = 0; i < 4; i++) cls(11 - i, m[i]);
  endtask
  task automatic pulse(input int k);
    ev[k] <= 1'b1;
    @(posedge clk);
    ev <= '0;
    repeat (3) @(posedge clk);
  endtask
  // Classic cycle; ack and data taken at the edge it is seen
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    req.adr <= {24'h00_0000, a};
    req.dat <= d;
    req.sel <= 4'hf;
    req.we <= w;
    req.cyc <= 1'b1;
    req.stb <= 1'b1;
    @(posedge clk iff rsp.ack === 1'b1);
    q = rsp.dat;
    req.cyc <= 1'b0;
    req.stb <= 1'b0;
    req.we <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic cfg_done();
    cfg_busy <= 1'b1;
    repeat (3) @(posedge clk);
    cfg_busy <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  // ==========================================================
  // Clock and watchdog
  // ==========================================================
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    conclude();
  end
  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    arst_n = 1'b0;
    btn_n = 1'b1;
    cfg_busy = 1'b0;
    ce = 1'b1;
    clr = 1'b0;
    ev = '0;
    tx = '0;
    rx = '0;
    perr = '0;
    req = '0;
    bad_count = 0;
    n_tests = 0;
    void'($urandom(32'h5653cf5e));
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    watch(5);
    for (int i = 0; i < 12; i++) cls(i, 2);
    repeat (10) @(posedge clk);
    m = '{2, 0, 2, 0};
    expect4();
    wb(1'b0, OFS_STAT, 0);
    chk(q, 32'h0000_0004);
    cfg_done();
    m[2] = 0;
    expect4();
    wb(1'b0, OFS_CTRL, 0);
    chk(q, CTRL_RST);
    wb(1'b0, 8'h10, 0);
    chk(q, 32'h0000_0000);
    wb(1'b1, OFS_IRQ, 32'h0000_0007);
    pulse(0);
    m[1] = 2;
    expect4();
    chk(irq, 1);
    wb(1'b0, OFS_IRQ, 0);
    chk(q[IRQ_FAULT], 1);
    wb(1'b1, OFS_MASK, 32'h0000_0001);
    chk(irq, 0);
    wb(1'b1, OFS_MASK, MASK_RST);
    wb(1'b1, OFS_IRQ, 32'h0000_0001);
    chk(irq, 0);
    btn_n <= 1'b0;
    repeat (4) @(posedge clk);
    btn_n <= 1'b1;
    repeat (6) @(posedge clk);
    m[1] = 0;
    m[2] = 2;
    expect4();
    cfg_done();
    pulse(1);
    expect4();
    cfg_done();
    m[2] = 0;
    pulse(4);
    m[3] = 1;
    expect4();
    pulse(2);
    m[3] = 0;
    expect4();
    // Boot command while frozen must be lost
    ce <= 1'b0;
    pulse(1);
    ce <= 1'b1;
    expect4();
    wb(1'b1, OFS_CTRL, 32'h0000_0004);
    pulse(4);
    pulse(3);
    expect4();
    wb(1'b1, OFS_CTRL, 32'h0000_0000);
    repeat (BURST_LIMIT) pulse(4);
    m[3] = 2;
    expect4();
    pulse(2);
    pulse(2);
    m[3] = 0;
    expect4();
    repeat (3) begin
      p = $urandom_range(3, 0);
      if ($urandom % 2) tx[p] <= 1'b1;
      else rx[p] <= 1'b1;
      @(posedge clk);
      tx <= '0;
      rx <= '0;
      watch(12);
      for (int j = 0; j < 4; j++) cls(4 + j, (j == p) ? 3 : 0);
      perr[p] <= 1'b1;
      @(posedge clk);
      perr <= '0;
      watch(12);
      cls(p, 3);
    end
    wb(1'b0, OFS_IRQ, 0);
    chk(q, 32'h0000_0006);
    wb(1'b1, OFS_CTRL, 32'h0000_0003);
    m[1] = 2;
    m[2] = 2;
    expect4();
    wb(1'b1, OFS_CTRL, 32'h0000_0001);
    pulse(0);
    m[2] = 0;
    expect4();
    conclude();
  end
endmodule
`default_nettype wire
